/* File: verilog/pcis_pkg.sv */
// Shared constants and carrier types for the configuration tail block
package pcis_pkg;
   // ------------------------------------------------------------
   // Configuration space byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_INTR_DW = 8'h3C;
   localparam logic [7:0] OFF_INTR_PIN = 8'h3D;
   localparam logic [7:0] OFF_MIN_GNT = 8'h3E;
   localparam logic [7:0] OFF_MAX_LAT = 8'h3F;
   localparam logic [7:0] OFF_INIT_GATE = 8'h40;
   localparam logic [7:0] OFF_SNOOP_0 = 8'h44;
   localparam logic [7:0] OFF_SNOOP_1 = 8'h48;
   localparam logic [7:0] OFF_STATUS_ALIAS = 8'h4C;
   localparam logic [7:0] DW_MASK = 8'hFC;

   // ------------------------------------------------------------
   // Fixed values and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] INTR_PIN_VALUE = 8'h01;
   localparam logic [7:0] MIN_GNT_VALUE = 8'h00;
   localparam logic [7:0] MAX_LAT_VALUE = 8'h00;
   localparam logic [31:0] GATE_RESET = 32'h00000000;
   localparam logic [31:0] SNOOP_RESET = 32'h00000000;
   localparam logic [31:0] SNOOP_READ_VALUE = 32'h00000000;
   localparam logic [31:0] HW_INIT_RESET = 32'h00000000;
   localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

   // ------------------------------------------------------------
   // Init gate field positions
   // ------------------------------------------------------------
   localparam int GATE_INIT_WR = 0;
   localparam int GATE_FIFO_WR = 1;
   localparam int GATE_REMAP = 2;
   localparam int GATE_RSVD = 3;
   localparam int GATE_S0_EN = 4;
   localparam int GATE_S0_IO = 5;
   localparam int GATE_S0_RD = 6;
   localparam int GATE_S1_EN = 7;
   localparam int GATE_S1_IO = 8;
   localparam int GATE_S1_RD = 9;
   localparam int GATE_SLI_DRV = 10;
   localparam int GATE_SLI_MST = 11;
   localparam logic [31:0] GATE_WR_MASK = 32'h00000FF7;
   localparam int HWB_SLI_EN = 23;
   localparam logic [1:0] HW_IDX_C = 2'h2;
   localparam logic [1:0] HW_IDX_D = 2'h3;

   // ------------------------------------------------------------
   // Carrier and state types
   // ------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [3:0] byte_en;
      logic [31:0] wdata;
   } pcis_cfg_req_t;
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } pcis_cfg_rsp_t;
   typedef struct packed {
      logic valid;
      logic is_io;
      logic is_read;
      logic [31:0] addr;
   } pcis_bus_cycle_t;
   typedef struct packed {
      logic en;
      logic io;
      logic rd;
      logic [31:0] addr;
   } pcis_snoop_cfg_t;
   typedef struct packed {
      logic hit;
   } pcis_snoop_state_t;
   typedef struct packed {
      logic [3:0][31:0] regs;
      logic [31:0] rd_data;
      logic dac_wr;
      logic [31:0] dac_data;
   } pcis_hw_state_t;
   typedef struct packed {
      logic [31:0] gate;
      logic [31:0] snoop0;
      logic [31:0] snoop1;
      logic ack;
      logic [31:0] rdata;
      logic vga_pass;
      logic fifo_vld;
      logic [31:0] fifo_data;
      logic sli_drv;
   } pcis_core_state_t;
   localparam pcis_core_state_t CORE_RESET = '{gate: GATE_RESET, snoop0: SNOOP_RESET,
      snoop1: SNOOP_RESET, default: '0};
endpackage

/* File: verilog/pcis_snoop_cmp.sv */
// One bus snoop comparator: space, direction and address match
`timescale 1ns/1ps
module pcis_snoop_cmp (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire pcis_pkg::pcis_snoop_cfg_t cfg,
   input wire pcis_pkg::pcis_bus_cycle_t cyc,
   output logic hit
);
   pcis_pkg::pcis_snoop_state_t st;
   pcis_pkg::pcis_snoop_state_t next_st;

   // Low address bits identify I/O ports, so memory ignores them
   function automatic logic addr_match(input logic [31:0] a, input logic [31:0] b,
                                       input logic io);
      addr_match = (a[31:2] == b[31:2]) && (!io || (a[1:0] == b[1:0]));
   endfunction

   // Hit only marks the cycle; it never reaches target decode
   always_comb begin
      next_st = st;
      next_st.hit = cyc.valid && cfg.en && (cyc.is_io == cfg.io) &&
         (cyc.is_read == cfg.rd) && addr_match(cyc.addr, cfg.addr, cfg.io);
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign hit = st.hit;
endmodule

/* File: verilog/pcis_hw_init.sv */
// Four hardware init registers with write gate and read remap
`timescale 1ns/1ps
module pcis_hw_init (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic wr_allow,
   input wire logic remap,
   input wire logic wr_valid,
   input wire logic [1:0] wr_index,
   input wire logic [31:0] wr_data,
   input wire logic [1:0] rd_index,
   input wire logic [31:0] dac_in,
   input wire logic [31:0] vsum_in,
   output logic [31:0] rd_data,
   output logic [3:0][31:0] init_regs,
   output logic dac_wr,
   output logic [31:0] dac_wdata
);
   pcis_pkg::pcis_hw_state_t st;
   pcis_pkg::pcis_hw_state_t next_st;
   logic wr_remapped;

   // Upper two slots move to the readback pair when remapped
   always_comb begin
      next_st = st;
      next_st.dac_wr = 1'b0;
      wr_remapped = remap && wr_index[1];
      if (wr_valid && wr_allow && !wr_remapped) begin
         next_st.regs[wr_index] = wr_data;
      end
      // Checksum slot is read only, its writes are dropped
      if (wr_valid && wr_allow && wr_remapped && (wr_index == pcis_pkg::HW_IDX_C)) begin
         next_st.dac_wr = 1'b1;
         next_st.dac_data = wr_data;
      end
      if (remap && (rd_index == pcis_pkg::HW_IDX_C)) begin
         next_st.rd_data = dac_in;
      end else if (remap && (rd_index == pcis_pkg::HW_IDX_D)) begin
         next_st.rd_data = vsum_in;
      end else begin
         next_st.rd_data = st.regs[rd_index];
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st <= '{regs: {4{pcis_pkg::HW_INIT_RESET}}, default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign rd_data = st.rd_data;
   assign init_regs = st.regs;
   assign dac_wr = st.dac_wr;
   assign dac_wdata = st.dac_data;
endmodule

/* File: verilog/pcis_cfg_tail.sv */
// Configuration space tail: fixed regs, init gate, bus snoop, alias
// Contract
// - Interrupt pin register reads fixed 0x1
// - Minimum grant byte reads fixed zero
// - Maximum latency byte reads fixed zero
// - Never request the bus; target only
// - Init register writes dropped unless gate bit0
// - Command FIFO writes pass only with bit1
// - Bit2 remaps third/fourth init slots to readbacks
// - Bits4-6 enable, space, direction of snoop0
// - Bits7-9 enable, space, direction of snoop1
// - Interleave drive when bits11,10 equal
// - Matching enabled snoop raises passthrough pin
// - Snoop match never alters target behaviour
// - Memory snoop compares address bits 31:2
// - Snoop address registers read back zero
// - Status alias reads live status value
`timescale 1ns/1ps
module pcis_cfg_tail (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire pcis_pkg::pcis_cfg_req_t cfg_req,
   output pcis_pkg::pcis_cfg_rsp_t cfg_rsp,
   input wire logic [31:0] status_in,
   input wire pcis_pkg::pcis_bus_cycle_t bus_cyc,
   output logic vga_pass,
   input wire logic host_cmd_valid,
   input wire logic [31:0] host_cmd_data,
   output logic fifo_wr_valid,
   output logic [31:0] fifo_wr_data,
   input wire logic hw_wr_valid,
   input wire logic [1:0] hw_wr_index,
   input wire logic [31:0] hw_wr_data,
   input wire logic [1:0] hw_rd_index,
   output logic [31:0] hw_rd_data,
   input wire logic [31:0] dac_in,
   input wire logic [31:0] vsum_in,
   output logic dac_wr,
   output logic [31:0] dac_wdata,
   output logic [3:0][31:0] init_regs,
   output logic sli_drive_en,
   output logic sli_master,
   output logic bus_req_n
);
   // ------------------------------------------------------------
   // State and local nets
   // ------------------------------------------------------------
   pcis_pkg::pcis_core_state_t st;
   pcis_pkg::pcis_core_state_t next_st;
   pcis_pkg::pcis_snoop_cfg_t snoop_cfg0;
   pcis_pkg::pcis_snoop_cfg_t snoop_cfg1;
   logic hit0;
   logic hit1;
   logic [7:0] dw_addr;
   logic cfg_wr;
   logic cfg_rd;
   logic [31:0] rd_word;

   // Byte lane merge shared by every writable word
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wdata,
                                              input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = wdata[8*i +: 8];
         end
      end
      lane_merge = res;
   endfunction

   // ------------------------------------------------------------
   // Snoop comparators
   // ------------------------------------------------------------
   // Comparator controls come straight from the gate bits
   always_comb begin
      snoop_cfg0.en = st.gate[pcis_pkg::GATE_S0_EN];
      snoop_cfg0.io = st.gate[pcis_pkg::GATE_S0_IO];
      snoop_cfg0.rd = st.gate[pcis_pkg::GATE_S0_RD];
      snoop_cfg0.addr = st.snoop0;
      snoop_cfg1.en = st.gate[pcis_pkg::GATE_S1_EN];
      snoop_cfg1.io = st.gate[pcis_pkg::GATE_S1_IO];
      snoop_cfg1.rd = st.gate[pcis_pkg::GATE_S1_RD];
      snoop_cfg1.addr = st.snoop1;
   end

   pcis_snoop_cmp u_snoop0 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .cfg(snoop_cfg0),
      .cyc(bus_cyc),
      .hit(hit0)
   );

   pcis_snoop_cmp u_snoop1 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .cfg(snoop_cfg1),
      .cyc(bus_cyc),
      .hit(hit1)
   );

   // ------------------------------------------------------------
   // Hardware init registers
   // ------------------------------------------------------------
   pcis_hw_init u_hw_init (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wr_allow(st.gate[pcis_pkg::GATE_INIT_WR]),
      .remap(st.gate[pcis_pkg::GATE_REMAP]),
      .wr_valid(hw_wr_valid),
      .wr_index(hw_wr_index),
      .wr_data(hw_wr_data),
      .rd_index(hw_rd_index),
      .dac_in(dac_in),
      .vsum_in(vsum_in),
      .rd_data(hw_rd_data),
      .init_regs(init_regs),
      .dac_wr(dac_wr),
      .dac_wdata(dac_wdata)
   );

   // ------------------------------------------------------------
   // Configuration read mux
   // ------------------------------------------------------------
   // Status alias is sampled in the request cycle, as memory reads are
   always_comb begin
      dw_addr = cfg_req.addr & pcis_pkg::DW_MASK;
      cfg_wr = cfg_req.valid && cfg_req.write;
      cfg_rd = cfg_req.valid && !cfg_req.write;
      rd_word = pcis_pkg::UNMAPPED_READ;
      case (dw_addr)
         pcis_pkg::OFF_INTR_DW: begin
            rd_word[{pcis_pkg::OFF_INTR_PIN[1:0], 3'b000} +: 8] =
               pcis_pkg::INTR_PIN_VALUE;
            rd_word[{pcis_pkg::OFF_MIN_GNT[1:0], 3'b000} +: 8] =
               pcis_pkg::MIN_GNT_VALUE;
            rd_word[{pcis_pkg::OFF_MAX_LAT[1:0], 3'b000} +: 8] =
               pcis_pkg::MAX_LAT_VALUE;
         end
         pcis_pkg::OFF_INIT_GATE: begin
            rd_word = st.gate;
         end
         pcis_pkg::OFF_SNOOP_0: begin
            rd_word = pcis_pkg::SNOOP_READ_VALUE;
         end
         pcis_pkg::OFF_SNOOP_1: begin
            rd_word = pcis_pkg::SNOOP_READ_VALUE;
         end
         pcis_pkg::OFF_STATUS_ALIAS: begin
            rd_word = status_in;
         end
         default: begin
            rd_word = pcis_pkg::UNMAPPED_READ;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // Every request is answered one cycle later, mapped or not
   always_comb begin
      next_st = st;
      next_st.ack = cfg_req.valid;
      next_st.rdata = cfg_rd ? rd_word : pcis_pkg::UNMAPPED_READ;
      // Fixed bytes and the alias ignore writes
      if (cfg_wr && (dw_addr == pcis_pkg::OFF_INIT_GATE)) begin
         next_st.gate = lane_merge(st.gate, cfg_req.wdata, cfg_req.byte_en) &
            pcis_pkg::GATE_WR_MASK;
      end
      if (cfg_wr && (dw_addr == pcis_pkg::OFF_SNOOP_0)) begin
         next_st.snoop0 = lane_merge(st.snoop0, cfg_req.wdata, cfg_req.byte_en);
      end
      if (cfg_wr && (dw_addr == pcis_pkg::OFF_SNOOP_1)) begin
         next_st.snoop1 = lane_merge(st.snoop1, cfg_req.wdata, cfg_req.byte_en);
      end
      // Rewriting the gate releases the pin; a new hit wins over it
      if (cfg_wr && (dw_addr == pcis_pkg::OFF_INIT_GATE)) begin
         next_st.vga_pass = 1'b0;
      end
      if (hit0 || hit1) begin
         next_st.vga_pass = 1'b1;
      end
      // Commands are dropped, not stalled, while the gate is shut
      next_st.fifo_vld = host_cmd_valid && st.gate[pcis_pkg::GATE_FIFO_WR];
      next_st.fifo_data = host_cmd_data;
      // Without interleave this device always owns its bus cycles
      next_st.sli_drv = !init_regs[1][pcis_pkg::HWB_SLI_EN] ||
         (st.gate[pcis_pkg::GATE_SLI_MST] == st.gate[pcis_pkg::GATE_SLI_DRV]);
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st <= pcis_pkg::CORE_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Snoop hits feed only the pin, never the answer path
   assign cfg_rsp.ack = st.ack;
   assign cfg_rsp.rdata = st.rdata;
   assign vga_pass = st.vga_pass;
   assign fifo_wr_valid = st.fifo_vld;
   assign fifo_wr_data = st.fifo_data;
   assign sli_drive_en = st.sli_drv;
   assign sli_master = st.gate[pcis_pkg::GATE_SLI_MST];
   // No master logic exists; request stays idle
   assign bus_req_n = 1'b1;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_rd(logic [7:0] a);
      cfg_req.valid && !cfg_req.write && ((cfg_req.addr & pcis_pkg::DW_MASK) == a);
   endsequence

   sequence s_gate_wr_full;
      cfg_req.valid && cfg_req.write && (cfg_req.byte_en == 4'hF) &&
         ((cfg_req.addr & pcis_pkg::DW_MASK) == pcis_pkg::OFF_INIT_GATE);
   endsequence

   sequence s_s0_mem_wr;
      bus_cyc.valid && st.gate[pcis_pkg::GATE_S0_EN] && !st.gate[pcis_pkg::GATE_S0_IO] &&
         !st.gate[pcis_pkg::GATE_S0_RD] && !bus_cyc.is_io && !bus_cyc.is_read &&
         (bus_cyc.addr[31:2] == st.snoop0[31:2]);
   endsequence

   a_intr_pin_value: assert property (s_rd(pcis_pkg::OFF_INTR_DW) |=>
      cfg_rsp.ack && (cfg_rsp.rdata[15:8] == 8'h01))
      else $error("interrupt pin byte not 0x1");

   a_min_gnt_zero: assert property (s_rd(pcis_pkg::OFF_INTR_DW) |=>
      cfg_rsp.rdata[23:16] == 8'h00)
      else $error("minimum grant byte not zero");

   a_max_lat_zero: assert property (s_rd(pcis_pkg::OFF_INTR_DW) |=>
      cfg_rsp.rdata[31:24] == 8'h00)
      else $error("maximum latency byte not zero");

   a_no_bus_request: assert property (cfg_req.valid |-> bus_req_n [*2])
      else $error("bus request asserted");

   a_init_wr_block: assert property (hw_wr_valid && !st.gate[0] |=>
      $stable(init_regs))
      else $error("init register written while gated");

   a_fifo_gate: assert property (fifo_wr_valid ==
      ($past(host_cmd_valid) && $past(st.gate[1])))
      else $error("command write passed wrong gate");

   a_remap_read: assert property (st.gate[2] && (hw_rd_index == 2'h3) |=>
      hw_rd_data == $past(vsum_in))
      else $error("remapped checksum read wrong");

   a_gate_fields: assert property (s_gate_wr_full |=>
      (st.gate[9] == $past(cfg_req.wdata[9])) && !st.gate[3] && (st.gate[31:12] == 20'h0))
      else $error("gate field write wrong");

   a_sli_drive: assert property (init_regs[1][23] && (st.gate[11] != st.gate[10])
      && $stable(init_regs[1]) && $stable(st.gate) |=> !sli_drive_en)
      else $error("interleave drive wrong");

   a_snoop_pass: assert property (s_s0_mem_wr |-> ##2 vga_pass)
      else $error("snoop match missed");

   a_snoop_low_bits: assert property (s_s0_mem_wr |=> hit0)
      else $error("memory snoop compared low bits");

   a_snoop_quiet: assert property (!cfg_req.valid |=> !cfg_rsp.ack)
      else $error("answer without request");

   a_snoop_rd_zero: assert property (s_rd(pcis_pkg::OFF_SNOOP_1) |=>
      cfg_rsp.ack && (cfg_rsp.rdata == 32'h0))
      else $error("snoop register read not zero");

   a_status_alias: assert property (s_rd(pcis_pkg::OFF_STATUS_ALIAS) |=>
      cfg_rsp.rdata == $past(status_in))
      else $error("status alias mismatch");

   a_snoop0_rd_zero: assert property (s_rd(pcis_pkg::OFF_SNOOP_0) |=>
      cfg_rsp.rdata == 32'h0)
      else $error("snoop 0 read not zero");

   a_init_wr_pass: assert property (hw_wr_valid && st.gate[0] && !st.gate[2] |=>
      init_regs[$past(hw_wr_index)] == $past(hw_wr_data))
      else $error("allowed init write lost");

   a_remap_dac_rd: assert property (st.gate[2] && (hw_rd_index == 2'h2) |=>
      hw_rd_data == $past(dac_in))
      else $error("remapped readback wrong");

   a_remap_wr_keep: assert property (hw_wr_valid && st.gate[2] && hw_wr_index[1] |=>
      $stable(init_regs[3:2]))
      else $error("remapped init slot written");

   a_dac_wr_pulse: assert property (hw_wr_valid && (hw_wr_index == 2'h2) &&
      st.gate[0] && st.gate[2] |=> dac_wr && (dac_wdata == $past(hw_wr_data)))
      else $error("remapped write not passed");

   a_fifo_data: assert property (host_cmd_valid && st.gate[1] |=>
      fifo_wr_data == $past(host_cmd_data))
      else $error("command data not passed");

   a_sli_drive_eq: assert property (init_regs[1][23] &&
      (st.gate[11] == st.gate[10]) |=> sli_drive_en)
      else $error("interleave drive missing");

   // Comparator 1 set for I/O reads, exact address
   sequence s_s1_io_rd;
      bus_cyc.valid && st.gate[7] && st.gate[8] && st.gate[9] &&
         bus_cyc.is_io && bus_cyc.is_read && (bus_cyc.addr == st.snoop1);
   endsequence

   a_snoop1_pass: assert property (s_s1_io_rd |-> ##2 vga_pass)
      else $error("snoop 1 match missed");

   a_snoop1_dir: assert property (s_s1_io_rd |=> hit1)
      else $error("snoop 1 direction missed");

   a_snoop0_off: assert property (!st.gate[4] |=> !hit0)
      else $error("disabled snoop 0 hit");

   a_snoop1_off: assert property (!st.gate[7] |=> !hit1)
      else $error("disabled snoop 1 hit");

   a_pin_sticky: assert property (vga_pass &&
      !(cfg_wr && (dw_addr == pcis_pkg::OFF_INIT_GATE)) |=> vga_pass)
      else $error("passthrough pin dropped");
endmodule

/* File: tb/pcis_host_model.sv */
// Host bridge model: config accesses and observed bus address phases
`timescale 1ns/1ps
module pcis_host_model (
   input wire logic sys_clk,
   output pcis_pkg::pcis_cfg_req_t cfg_req,
   input wire pcis_pkg::pcis_cfg_rsp_t cfg_rsp,
   output pcis_pkg::pcis_bus_cycle_t bus_cyc
);
   // Idle at time zero
   initial begin
      cfg_req = '0;
      bus_cyc = '0;
   end

   // One-cycle request; the answer is taken one cycle later
   task automatic cfg_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic ack, output logic [31:0] rd);
      @(negedge sys_clk);
      cfg_req <= '{valid: 1'b1, write: wr, addr: a, byte_en: 4'hF, wdata: d};
      @(negedge sys_clk);
      ack = cfg_rsp.ack;
      rd = cfg_rsp.rdata;
      // Released lines show the inverse so stale data never matches
      cfg_req <= '{valid: 1'b0, write: ~wr, addr: ~a, byte_en: 4'h0, wdata: ~d};
   endtask

   // Address phase of a foreign transfer, one cycle long
   task automatic snoop_cycle(input logic io, input logic rd, input logic [31:0] a);
      @(negedge sys_clk);
      bus_cyc <= '{valid: 1'b1, is_io: io, is_read: rd, addr: a};
      @(negedge sys_clk);
      bus_cyc <= '{valid: 1'b0, is_io: ~io, is_read: ~rd, addr: ~a};
   endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the configuration tail block
`timescale 1ns/1ps
module testbench;
   logic sys_clk;
   logic rst_n;
   pcis_pkg::pcis_cfg_req_t cfg_req;
   pcis_pkg::pcis_cfg_rsp_t cfg_rsp;
   pcis_pkg::pcis_bus_cycle_t bus_cyc;
   logic [31:0] status_in, host_cmd_data, hw_wr_data, dac_in, vsum_in;
   logic [31:0] fifo_wr_data, hw_rd_data, dac_wdata, rd, a, g;
   logic host_cmd_valid, hw_wr_valid, fifo_wr_valid, dac_wr, vga_pass;
   logic sli_drive_en, sli_master, bus_req_n, ack, io, r;
   logic [1:0] hw_wr_index, hw_rd_index;
   logic [3:0][31:0] init_regs;
   int n_mismatch = 0;
   int checks = 0;

   pcis_cfg_tail dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_req(cfg_req),
      .cfg_rsp(cfg_rsp), .status_in(status_in), .bus_cyc(bus_cyc), .vga_pass(vga_pass),
      .host_cmd_valid(host_cmd_valid), .host_cmd_data(host_cmd_data),
      .fifo_wr_valid(fifo_wr_valid), .fifo_wr_data(fifo_wr_data), .hw_wr_valid(hw_wr_valid),
      .hw_wr_index(hw_wr_index), .hw_wr_data(hw_wr_data), .hw_rd_index(hw_rd_index),
      .hw_rd_data(hw_rd_data), .dac_in(dac_in), .vsum_in(vsum_in), .dac_wr(dac_wr),
      .dac_wdata(dac_wdata), .init_regs(init_regs), .sli_drive_en(sli_drive_en),
      .sli_master(sli_master), .bus_req_n(bus_req_n));
   pcis_host_model host_u (.sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
      .bus_cyc(bus_cyc));

   // ----
   // Clock, checking and access tasks
   // ----
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic results();
      $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cfg_wr(input logic [7:0] ad, input logic [31:0] d);
      host_u.cfg_xfer(1'b1, ad, d, ack, rd);
      check(32'(ack), 32'h1, "write ack");
   endtask

   // Every access is acknowledged, mapped or not
   task automatic cfg_rd(input logic [7:0] ad, input logic [31:0] exp);
      host_u.cfg_xfer(1'b0, ad, 32'h0, ack, rd);
      check(32'(ack), 32'h1, "read ack");
      check(rd, exp, "config read");
   endtask

   task automatic hw_write(input logic [1:0] i, input logic [31:0] d);
      @(negedge sys_clk);
      hw_wr_valid = 1'b1;
      hw_wr_index = i;
      hw_wr_data = d;
      @(negedge sys_clk);
      hw_wr_valid = 1'b0;
      hw_wr_index = ~i;
      hw_wr_data = ~d;
   endtask

   task automatic hw_read(input logic [1:0] i, input logic [31:0] exp);
      @(negedge sys_clk);
      hw_rd_index = i;
      @(negedge sys_clk);
      check(hw_rd_data, exp, "init read");
   endtask

   // Command write; the FIFO strobe shows one cycle later or never
   task automatic host_cmd(input logic [31:0] d, input logic exp);
      @(negedge sys_clk);
      host_cmd_valid = 1'b1;
      host_cmd_data = d;
      @(negedge sys_clk);
      host_cmd_valid = 1'b0;
      host_cmd_data = ~d;
      check(32'(fifo_wr_valid), 32'(exp), "fifo strobe");
      if (exp) check(fifo_wr_data, d, "fifo data");
   endtask

   // Passthrough pin is looked at two cycles after the address phase
   task automatic snoop_chk(input logic sio, input logic srd, input logic [31:0] sa,
         input logic exp);
      host_u.snoop_cycle(sio, srd, sa);
      @(negedge sys_clk);
      check(32'(cfg_rsp.ack), 32'h0, "ack during snoop");
      check(32'(vga_pass), 32'(exp), "passthrough pin");
   endtask

   // Target only: the bus request stays idle all run
   always @(negedge sys_clk) begin
      if (rst_n === 1'b1) check(32'(bus_req_n), 32'h1, "bus request");
   end

   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      #(4000 * 50);
      n_mismatch++;
      $display("wrong value at %0t: watchdog expired", $time);
      results();
   end

   // ----
   // Main sequence
   // ----
   initial begin
      rst_n = 1'b0;
      status_in = 32'h0;
      host_cmd_valid = 1'b0;
      host_cmd_data = 32'h0;
      hw_wr_valid = 1'b0;
      hw_wr_index = 2'h0;
      hw_wr_data = 32'h0;
      hw_rd_index = 2'h0;
      dac_in = 32'h1234ABCD;
      vsum_in = 32'h5A5A0F0F;
      repeat (6) @(negedge sys_clk);
      rst_n = 1'b1;
      cfg_rd(8'h3C, 32'h00000100);
      cfg_wr(8'h3C, 32'hFFFFFFFF);
      cfg_rd(8'h3C, 32'h00000100);
      cfg_rd(8'h40, 32'h00000000);
      cfg_rd(8'h50, 32'h00000000);
      cfg_wr(8'h40, 32'hFFFFFFFF);
      cfg_rd(8'h40, 32'h00000FF7);
      cfg_wr(8'h40, 32'h00000000);
      $display("test fixed and gate registers done");
      hw_write(2'h1, 32'h00800000);
      check(init_regs[1], 32'h0, "blocked init write");
      host_cmd(32'hCAFE0001, 1'b0);
      cfg_wr(8'h40, 32'h00000003);
      for (int i = 0; i < 4; i++) begin
         hw_write(2'(i), 32'hC0DE0000 + 32'(i));
         check(init_regs[i], 32'hC0DE0000 + 32'(i), "init write");
      end
      host_cmd(32'hCAFE0002, 1'b1);
      host_cmd(32'hCAFE0003, 1'b1);
      $display("test write gating done");
      cfg_wr(8'h40, 32'h00000007);
      hw_read(2'h2, 32'h1234ABCD);
      hw_read(2'h3, 32'h5A5A0F0F);
      hw_read(2'h1, 32'hC0DE0001);
      hw_write(2'h2, 32'h00AB00CD);
      check(32'(dac_wr), 32'h1, "remapped write strobe");
      check(dac_wdata, 32'h00AB00CD, "remapped write data");
      check(init_regs[2], 32'hC0DE0002, "remapped slot kept");
      hw_write(2'h3, 32'h00EE00FF);
      check(init_regs[3], 32'hC0DE0003, "remapped slot kept");
      check(32'(dac_wr), 32'h0, "checksum slot write");
      $display("test remap done");
      cfg_wr(8'h40, 32'h00000001);
      hw_write(2'h1, 32'h00800000);
      for (int c = 0; c < 4; c++) begin
         cfg_wr(8'h40, {20'h0, 2'(c), 10'h001});
         repeat (2) @(negedge sys_clk);
         check(32'(sli_drive_en), 32'(c == 0 || c == 3), "interleave drive");
         check(32'(sli_master), 32'(c >> 1), "interleave role");
      end
      hw_write(2'h1, 32'h00000000);
      repeat (2) @(negedge sys_clk);
      check(32'(sli_drive_en), 32'h1, "drive without interleave");
      $display("test interleave done");
      cfg_wr(8'h44, 32'h000003C4);
      cfg_wr(8'h48, 32'hA0000010);
      cfg_rd(8'h44, 32'h00000000);
      cfg_rd(8'h48, 32'h00000000);
      cfg_wr(8'h40, 32'h00000002);
      snoop_chk(1'b0, 1'b0, 32'h000003C4, 1'b0);
      // Every comparator, space and direction combination
      for (int k = 0; k < 8; k++) begin
         io = k[1];
         r = k[0];
         a = k[2] ? 32'hA0000010 : 32'h000003C4;
         g = k[2] ? {22'h0, r, io, 1'b1, 7'h02} : {25'h0, r, io, 1'b1, 4'h2};
         cfg_wr(8'h40, g);
         check(32'(vga_pass), 32'h0, "pin cleared");
         snoop_chk(io, ~r, a, 1'b0);
         snoop_chk(~io, r, a, 1'b0);
         snoop_chk(io, r, a ^ 32'h4, 1'b0);
         snoop_chk(io, r, a ^ 32'h1, ~io);
         cfg_wr(8'h40, g);
         snoop_chk(io, r, a, 1'b1);
      end
      $display("test bus snoop done");
      status_in = 32'hA5C31E0F;
      cfg_rd(8'h4C, 32'hA5C31E0F);
      cfg_wr(8'h4C, 32'h00000000);
      status_in = 32'h5A3CE1F0;
      cfg_rd(8'h4C, 32'h5A3CE1F0);
      $display("test status alias done");
      results();
   end
endmodule
